//--- rtl/ccir_pkg.sv
/*
 Constants for the channel calibration and identification register bank.
 Assumes one 10 MHz system clock and an external two-wire front end that
 hands over register pointer, data and strobes on that clock.
*/
// Notes on behaviour
// - Offset trim word: five-bit signed integer picofarads, eleven fraction bits.
// - Offset trim spans about minus to plus sixteen pF, fine residual offset.
// - Each channel adds its own offset trim; four registers at consecutive addresses.
// - A coarse offset array of up to about 100 pF adds to the fine trim.
// - Gain trim word: unsigned, two integer bits, fourteen fraction bits.
// - Applied gain is the raw word over two to the fourteenth, zero to under four.
// - Four gain trim registers at consecutive addresses, each on its own channel.
// - Read-only 16-bit maker code register.
// - Read-only 16-bit part code register.
// - With only single-ended measurements, both shield drivers are tied together.
package ccir_pkg;

   // Register pointer and data
   localparam int unsigned CCIR_ADDR_W   = 8;
   localparam int unsigned CCIR_REG_W    = 16;
   localparam int unsigned CCIR_NUM_CH   = 4;
   localparam int unsigned CCIR_IDX_W    = 2;

   // Register offsets
   localparam logic [7:0] CCIR_OFS_TRIM_FIRST  = 8'h0d;
   localparam logic [7:0] CCIR_OFS_TRIM_LAST   = 8'h10;
   localparam logic [7:0] CCIR_GAIN_TRIM_FIRST = 8'h11;
   localparam logic [7:0] CCIR_GAIN_TRIM_LAST  = 8'h14;
   localparam logic [7:0] CCIR_MAKER_CODE_ADDR = 8'hfe;
   localparam logic [7:0] CCIR_PART_CODE_ADDR  = 8'hff;

   // Field layout of the trim words
   localparam int unsigned CCIR_OFS_INT_LSB   = 11;
   localparam int unsigned CCIR_OFS_FRAC_W    = 11;
   localparam int unsigned CCIR_GAIN_INT_LSB  = 14;
   localparam int unsigned CCIR_GAIN_FRAC_W   = 14;

   // Values after reset: zero offset, unity gain
   localparam logic [15:0] CCIR_OFS_TRIM_RST  = 16'h0000;
   localparam logic [15:0] CCIR_GAIN_TRIM_RST = 16'h4000;
   localparam logic [15:0] CCIR_RDATA_RST     = 16'h0000;

   // Identification defaults, values are arbitrary
   localparam logic [15:0] CCIR_MAKER_CODE_DEF = 16'h0a5a;
   localparam logic [15:0] CCIR_PART_CODE_DEF  = 16'h0c3c;

   // Measurement path: signed capacitance, 2^-19 pF per step
   localparam int unsigned CCIR_MEAS_W      = 24;
   localparam int unsigned CCIR_MEAS_FRAC_W = 19;
   localparam int unsigned CCIR_ACC_W       = 32;
   localparam int unsigned CCIR_OFS_ALIGN   = CCIR_MEAS_FRAC_W - CCIR_OFS_FRAC_W;
   localparam int unsigned CCIR_COARSE_W    = 5;
   // Coarse step 3.125 pF in measurement steps (25/8 * 2^19)
   localparam logic [31:0] CCIR_COARSE_STEP = 32'h0019_0000;
   localparam int unsigned CCIR_PROD_W      = CCIR_ACC_W + CCIR_REG_W + 1;

   // Cycles from a measurement strobe to its corrected result
   localparam int unsigned CCIR_TRIM_LAT    = 2;

   typedef logic [15:0] ccir_word_t;

endpackage

//--- rtl/ccir_chan_trim.sv
/*
 One channel of the correction path: fine offset, coarse offset, then gain.
 Assumes its trim words are stable register outputs on the same clock.
*/
`timescale 1ns/100ps
module ccir_chan_trim
   import ccir_pkg::*;
(
   // Clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_n_i,
   // Trim settings
   input  wire logic [CCIR_REG_W-1:0]        offset_trim_i,
   input  wire logic [CCIR_REG_W-1:0]        gain_trim_i,
   input  wire logic [CCIR_COARSE_W-1:0]     coarse_code_i,
   input  wire logic                         coarse_en_i,
   // Raw measurement
   input  wire logic [CCIR_MEAS_W-1:0]       meas_i,
   input  wire logic                         meas_valid_i,
   // Corrected result
   output logic      [CCIR_ACC_W-1:0]        result_o,
   output logic                              result_valid_o
);

   logic signed [CCIR_ACC_W-1:0]  meas_ext;
   logic signed [CCIR_ACC_W-1:0]  ofs_ext;
   logic signed [CCIR_ACC_W-1:0]  coarse_val;
   logic signed [CCIR_ACC_W-1:0]  sum_reg;
   logic                          sum_valid_reg;
   logic signed [CCIR_PROD_W-1:0] prod;
   logic signed [CCIR_ACC_W-1:0]  scaled;
   logic                          ovf;

   assign meas_ext = $signed({{(CCIR_ACC_W-CCIR_MEAS_W){meas_i[CCIR_MEAS_W-1]}}, meas_i});
   // Offset is signed Q5.11, aligned up to the measurement grid
   assign ofs_ext = $signed({{(CCIR_ACC_W-CCIR_REG_W){offset_trim_i[CCIR_REG_W-1]}},
                             offset_trim_i}) <<< CCIR_OFS_ALIGN;
   // Coarse array tops out near 97 pF
   assign coarse_val = coarse_en_i
                       ? $signed({{(CCIR_ACC_W-CCIR_COARSE_W){1'b0}}, coarse_code_i}
                                 * CCIR_COARSE_STEP)
                       : '0;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sum_reg       <= '0;
         sum_valid_reg <= 1'b0;
      end
      else
      begin
         sum_valid_reg <= meas_valid_i;
         if (meas_valid_i)
         begin
            sum_reg <= meas_ext + ofs_ext + coarse_val;
         end
      end
   end

   // Gain word is unsigned, so a zero sign bit is prepended
   assign prod   = sum_reg * $signed({1'b0, gain_trim_i});
   assign scaled = prod[CCIR_GAIN_FRAC_W +: CCIR_ACC_W];
   // Gain below four can still push a large sum past 32 bits
   assign ovf    = (prod[CCIR_PROD_W-1:CCIR_GAIN_FRAC_W+CCIR_ACC_W-1] != '0) &&
                   (prod[CCIR_PROD_W-1:CCIR_GAIN_FRAC_W+CCIR_ACC_W-1] != '1);

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         result_o       <= '0;
         result_valid_o <= 1'b0;
      end
      else
      begin
         result_valid_o <= sum_valid_reg;
         if (sum_valid_reg)
         begin
            if (ovf)
            begin
               result_o <= prod[CCIR_PROD_W-1] ? {1'b1, {(CCIR_ACC_W-1){1'b0}}}
                                               : {1'b0, {(CCIR_ACC_W-1){1'b1}}};
            end
            else
            begin
               result_o <= scaled;
            end
         end
      end
   end

endmodule

//--- rtl/ccir_regs.sv
/*
 Calibration and identification register bank with four correction paths.
 Assumes the two-wire front end outside delivers one register access per
 strobe, already on sys_clk_i; measurement strobes come from the same clock.
*/
`timescale 1ns/100ps
module ccir_regs
   import ccir_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = CCIR_MAKER_CODE_DEF,
   parameter logic [15:0] PART_CODE  = CCIR_PART_CODE_DEF
)
(
   // Clock and reset
   input  wire logic                                     sys_clk_i,
   input  wire logic                                     rst_n_i,
   // Register access from the serial front end
   input  wire logic [CCIR_ADDR_W-1:0]                   reg_addr_i,
   input  wire logic                                     reg_wr_i,
   input  wire logic [CCIR_REG_W-1:0]                    reg_wdata_i,
   input  wire logic                                     reg_rd_i,
   output logic      [CCIR_REG_W-1:0]                    reg_rdata_o,
   output logic                                          reg_rvalid_o,
   output logic                                          reg_refused_o,
   // Measurement side, one lane per sense input
   input  wire logic [CCIR_NUM_CH-1:0][CCIR_MEAS_W-1:0]  meas_i,
   input  wire logic [CCIR_NUM_CH-1:0]                   meas_valid_i,
   input  wire logic [CCIR_NUM_CH-1:0][CCIR_COARSE_W-1:0] coarse_code_i,
   input  wire logic [CCIR_NUM_CH-1:0]                   coarse_en_i,
   output logic      [CCIR_NUM_CH-1:0][CCIR_ACC_W-1:0]   corrected_o,
   output logic      [CCIR_NUM_CH-1:0]                   corrected_valid_o,
   // Shield drivers
   input  wire logic                                     single_ended_only_i,
   output logic                                          shield_tie_o
);

   ccir_word_t                   offset_trim_reg [CCIR_NUM_CH];
   ccir_word_t                   gain_trim_reg   [CCIR_NUM_CH];
   logic                         ofs_hit;
   logic                         gain_hit;
   logic                         maker_hit;
   logic                         part_hit;
   logic                         rw_hit;
   logic [CCIR_ADDR_W-1:0]       ofs_rel;
   logic [CCIR_ADDR_W-1:0]       gain_rel;
   logic [CCIR_IDX_W-1:0]        ofs_idx;
   logic [CCIR_IDX_W-1:0]        gain_idx;
   ccir_word_t                   rdata_next;
   logic                         refused_next;
   logic                         shield_tie_reg;

   // Address decode
   assign ofs_hit   = (reg_addr_i >= CCIR_OFS_TRIM_FIRST) &&
                      (reg_addr_i <= CCIR_OFS_TRIM_LAST);
   assign gain_hit  = (reg_addr_i >= CCIR_GAIN_TRIM_FIRST) &&
                      (reg_addr_i <= CCIR_GAIN_TRIM_LAST);
   assign maker_hit = (reg_addr_i == CCIR_MAKER_CODE_ADDR);
   assign part_hit  = (reg_addr_i == CCIR_PART_CODE_ADDR);
   assign rw_hit    = ofs_hit || gain_hit;
   assign ofs_rel   = reg_addr_i - CCIR_OFS_TRIM_FIRST;
   assign gain_rel  = reg_addr_i - CCIR_GAIN_TRIM_FIRST;
   assign ofs_idx   = ofs_rel[CCIR_IDX_W-1:0];
   assign gain_idx  = gain_rel[CCIR_IDX_W-1:0];

   // Offset trim storage
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < CCIR_NUM_CH; i++)
         begin
            offset_trim_reg[i] <= CCIR_OFS_TRIM_RST;
         end
      end
      else if (reg_wr_i && ofs_hit)
      begin
         offset_trim_reg[ofs_idx] <= reg_wdata_i;
      end
   end

   // Gain trim storage
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < CCIR_NUM_CH; i++)
         begin
            gain_trim_reg[i] <= CCIR_GAIN_TRIM_RST;
         end
      end
      else if (reg_wr_i && gain_hit)
      begin
         gain_trim_reg[gain_idx] <= reg_wdata_i;
      end
   end

   // Read mux; unmapped pointers read as zero
   always_comb
   begin
      rdata_next = '0;
      if (ofs_hit)
      begin
         rdata_next = offset_trim_reg[ofs_idx];
      end
      else if (gain_hit)
      begin
         rdata_next = gain_trim_reg[gain_idx];
      end
      else if (maker_hit)
      begin
         rdata_next = MAKER_CODE;
      end
      else if (part_hit)
      begin
         rdata_next = PART_CODE;
      end
   end

   // Identification words take no writes; such writes are flagged
   always_comb
   begin
      refused_next = 1'b0;
      if (reg_wr_i && !rw_hit)
      begin
         refused_next = 1'b1;
      end
      else if (reg_rd_i && !(rw_hit || maker_hit || part_hit))
      begin
         refused_next = 1'b1;
      end
   end

   // Read data held until the next read
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= CCIR_RDATA_RST;
      end
      else if (reg_rd_i)
      begin
         reg_rdata_o <= rdata_next;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rvalid_o  <= 1'b0;
         reg_refused_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o  <= reg_rd_i;
         reg_refused_o <= refused_next;
      end
   end

   // Shield pair is tied only for ground-referenced measurements
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         shield_tie_reg <= 1'b0;
      end
      else
      begin
         shield_tie_reg <= single_ended_only_i;
      end
   end

   assign shield_tie_o = shield_tie_reg;

   // One correction path per sense input, each fed only its own trims
   for (genvar ch = 0; ch < CCIR_NUM_CH; ch++)
   begin : g_chan
      ccir_chan_trim u_trim
      (
         .sys_clk_i      (sys_clk_i),
         .rst_n_i        (rst_n_i),
         .offset_trim_i  (offset_trim_reg[ch]),
         .gain_trim_i    (gain_trim_reg[ch]),
         .coarse_code_i  (coarse_code_i[ch]),
         .coarse_en_i    (coarse_en_i[ch]),
         .meas_i         (meas_i[ch]),
         .meas_valid_i   (meas_valid_i[ch]),
         .result_o       (corrected_o[ch]),
         .result_valid_o (corrected_valid_o[ch])
      );
   end

endmodule

//--- verif/ccir_regs_sva.sv
/* Port checker for the calibration register bank.
 Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/100ps
module ccir_regs_sva
   import ccir_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = CCIR_MAKER_CODE_DEF,
   parameter logic [15:0] PART_CODE  = CCIR_PART_CODE_DEF
)
(
   // Clock, reset and register access
   input wire logic                   sys_clk_i,
   input wire logic                   rst_n_i,
   input wire logic [CCIR_ADDR_W-1:0] reg_addr_i,
   input wire logic                   reg_wr_i,
   input wire logic [CCIR_REG_W-1:0]  reg_wdata_i,
   input wire logic                   reg_rd_i,
   input wire logic [CCIR_REG_W-1:0]  reg_rdata_o,
   input wire logic                   reg_rvalid_o,
   input wire logic                   reg_refused_o,
   // Measurement and shield
   input wire logic [CCIR_NUM_CH-1:0] meas_valid_i,
   input wire logic [CCIR_NUM_CH-1:0] corrected_valid_o,
   input wire logic                   single_ended_only_i,
   input wire logic                   shield_tie_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence gain_wr_s;
      reg_wr_i && reg_addr_i == CCIR_GAIN_TRIM_FIRST;
   endsequence
   sequence gain_rd_s;
      reg_rd_i && reg_addr_i == CCIR_GAIN_TRIM_FIRST;
   endsequence
   rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   no_spur_valid_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("read valid without read");
   maker_read_a: assert property (reg_rd_i && reg_addr_i == CCIR_MAKER_CODE_ADDR
      |=> reg_rdata_o == MAKER_CODE) else $error("maker code wrong");
   part_read_a: assert property (reg_rd_i && reg_addr_i == CCIR_PART_CODE_ADDR
      |=> reg_rdata_o == PART_CODE) else $error("part code wrong");
   id_write_a: assert property (reg_wr_i && reg_addr_i >= CCIR_MAKER_CODE_ADDR
      |=> reg_refused_o) else $error("code write not refused");
   unmapped_rd_a: assert property (reg_rd_i && reg_addr_i == 8'h20
      |=> reg_refused_o && reg_rdata_o == 16'h0000) else $error("unmapped read");
   wr_rd_a: assert property (gain_wr_s ##1 gain_rd_s
      |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("gain write lost");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   meas_lane_a: assert property (##2 corrected_valid_o == $past(meas_valid_i, 2))
      else $error("result lane or latency wrong");
   shield_tie_a: assert property ($changed(single_ended_only_i)
      |=> shield_tie_o == $past(single_ended_only_i)) else $error("shield tie late");
endmodule
bind ccir_regs ccir_regs_sva #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) ccir_regs_sva_i (
   .sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
   .reg_rvalid_o, .reg_refused_o, .meas_valid_i, .corrected_valid_o, .single_ended_only_i,
   .shield_tie_o);

//--- verif/ccir_host_model.sv
/* Register host model issuing single-word accesses.
 Assumes tasks are entered just after a rising edge. */
`timescale 1ns/100ps
module ccir_host_model
   import ccir_pkg::*;
(
   // Clock and answers
   input  wire logic                   sys_clk_i,
   input  wire logic [CCIR_REG_W-1:0]  reg_rdata_i,
   input  wire logic                   reg_rvalid_i,
   input  wire logic                   reg_refused_i,
   // Requests
   output logic      [CCIR_ADDR_W-1:0] reg_addr_o,
   output logic                        reg_wr_o,
   output logic      [CCIR_REG_W-1:0]  reg_wdata_o,
   output logic                        reg_rd_o
);
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 16'h0000;
      reg_rd_o = 1'b0;
   end
   // Gap off lets a read follow in the next cycle
   task automatic write(input logic [7:0] a, input logic [15:0] d, input bit gap,
                        output logic refused);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge sys_clk_i) #1;
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
      refused = reg_refused_i;
      if (gap)
         @(posedge sys_clk_i) #1;
   endtask
   task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v,
                       output logic refused);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge sys_clk_i) #1;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
      v = reg_rvalid_i;
      refused = reg_refused_i;
      @(posedge sys_clk_i) #1;
   endtask
endmodule

//--- verif/tb_top.sv
/* Self-checking bench for the register bank.
 Assumes the host model drives all register strobes. */
`timescale 1ns/100ps
module tb_top;
   import ccir_pkg::*;
   // Values are arbitrary
   localparam logic [15:0] MAKER = 16'h1357;
   localparam logic [15:0] PART  = 16'h2468;
   logic                   sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_refused_o;
   logic [7:0]             reg_addr_i;
   logic [15:0]            reg_wdata_i, reg_rdata_o, d;
   logic [3:0][23:0]       meas_i;
   logic [3:0]             meas_valid_i, coarse_en_i, corrected_valid_o;
   logic [3:0][4:0]        coarse_code_i;
   logic [3:0][31:0]       corrected_o;
   logic                   single_ended_only_i, shield_tie_o, v, r;
   int                     failures, check_count;
   ccir_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) ccir_regs_i (.sys_clk_i, .rst_n_i,
      .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
      .reg_refused_o, .meas_i, .meas_valid_i, .coarse_code_i, .coarse_en_i, .corrected_o,
      .corrected_valid_o, .single_ended_only_i, .shield_tie_o);
   ccir_host_model ccir_host_model_i (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o), .reg_refused_i(reg_refused_o), .reg_addr_o(reg_addr_i),
      .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic test_ids();
      for (int i = 0; i < 8; i++)
      begin
         ccir_host_model_i.read(8'(8'h0d + i), d, v, r);
         chk("trim reset", (i < 4) ? 16'h0000 : 16'h4000, d);
      end
      ccir_host_model_i.read(8'hfe, d, v, r);
      chk("maker", MAKER, d);
      ccir_host_model_i.read(8'hff, d, v, r);
      chk("part", PART, d);
      ccir_host_model_i.write(8'hff, 16'h5555, 1'b1, r);
      chk("part write refused", 1'b1, r);
      ccir_host_model_i.read(8'hff, d, v, r);
      chk("part kept", PART, d);
      ccir_host_model_i.read(8'h20, d, v, r);
      chk("unmapped refused", 1'b1, r);
      chk("unmapped zero", 16'h0000, d);
      $display("test ids done");
   endtask
   task automatic test_rw();
      for (int i = 0; i < 8; i++)
      begin
         ccir_host_model_i.write(8'(8'h0d + i), 16'(16'h1111 * (i + 1)), 1'b0, r);
         chk("trim write taken", 1'b0, r);
         ccir_host_model_i.read(8'(8'h0d + i), d, v, r);
         chk("trim back", 16'(16'h1111 * (i + 1)), d);
         chk("read valid", 1'b1, v);
      end
      $display("test rw done");
   endtask
   task automatic test_meas();
      logic [15:0] t[8] = '{16'h0000, 16'h0800, 16'h8000, 16'h0000,
                            16'h4000, 16'h8000, 16'h4000, 16'h4000};
      for (int i = 0; i < 8; i++)
         ccir_host_model_i.write(8'(8'h0d + i), t[i], 1'b1, r);
      meas_i = {24'h000000, 24'h000000, 24'h080000, 24'h080000};
      coarse_code_i[3] = 5'h02;
      coarse_en_i = 4'h8;
      meas_valid_i = 4'hf;
      @(posedge sys_clk_i) #1;
      meas_valid_i = 4'h0;
      // Valid stands one cycle only, one edge after the strobe edge
      @(posedge sys_clk_i) #1;
      chk("valid lanes", 4'hf, corrected_valid_o);
      chk("unity lane", 32'h00080000, corrected_o[0]);
      chk("offset gain", 32'h00200000, corrected_o[1]);
      chk("min offset", 32'hff800000, corrected_o[2]);
      chk("coarse", 32'h00320000, corrected_o[3]);
      $display("test meas done");
   endtask
   task automatic test_shield();
      single_ended_only_i = 1'b1;
      @(posedge sys_clk_i) #1;
      chk("shield tie", 1'b1, shield_tie_o);
      single_ended_only_i = 1'b0;
      @(posedge sys_clk_i) #1;
      chk("shield free", 1'b0, shield_tie_o);
      $display("test shield done");
   endtask
   initial
   begin
      #2000000;
      failures++;
      $display("MISMATCH run time expected done seen timeout");
      give_verdict();
   end
   initial
   begin
      failures = 0;
      check_count = 0;
      rst_n_i = 1'b0;
      meas_i = '0;
      meas_valid_i = 4'h0;
      coarse_code_i = '0;
      coarse_en_i = 4'h0;
      single_ended_only_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 rst_n_i = 1'b1;
      test_ids();
      test_rw();
      test_meas();
      test_shield();
      give_verdict();
   end
endmodule
